// >>> pkg/ssc_defines.vh
// Constants for the serial setup chain loader
`ifndef SSC_DEFINES_VH
`define SSC_DEFINES_VH
`define SSC_SETUP_LEN      16'd64
`define SSC_LEN_W          16
`define SSC_SYS_CLK_MHZ    20
`define SSC_STRAP_WAIT     16'd2
`define SSC_ST_IDLE        2'h0
`define SSC_ST_LOAD        2'h1
`define SSC_ST_DONE        2'h2
`endif

// >>> design/ssc_sync2.v
// Two-flop synchroniser with rising edge detect on the settled level
module ssc_sync2 (
  input  wire i_sys_clk,   // System clock
  input  wire i_rst_n,     // Async reset, active low
  input  wire i_async,     // Level from outside the clock domain
  input  wire i_rst_val,   // Masks o_rise when high, kept constant
  output wire o_level,     // Synchronised level
  output wire o_rise       // One-cycle pulse on rising edge
);
  reg meta_r;
  reg sync_r;
  reg prev_r;
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= 1'b1;
      sync_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      meta_r <= i_async;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end
  assign o_level = sync_r;
  assign o_rise  = sync_r & ~prev_r & ~i_rst_val;
endmodule

// >>> design/ssc_loader.v
// Serial setup loader with chain enable and data pass-through
// What this block does
// - Enable output follows enable input only after programming finishes.
// - After programming, enable output tracks enable input low and high.
// - Completion shown for serial load and for default setup alike.
// - Low enable output means the device is ready for normal operation.
// - Unprogrammed: capture serial data on shift clock rise while enable low.
// - Loaded with enable output low: serial data passes straight through.
// - Setup storage is a shift register filled bit by bit.
`include "ssc_defines.vh"
module ssc_loader (
  input  wire                     i_sys_clk,          // System clock, 20 MHz
  input  wire                     i_rst_n,            // Master reset, low
  input  wire                     i_serial_mode,      // 1: serial load, 0: default
  input  wire                     i_shift_clk,        // Serial shift clock pin
  input  wire                     i_chain_enable_in,  // Chain enable, low active
  input  wire                     i_serial_in,        // Serial data pin
  output reg                      o_chain_enable_out, // Chain enable out
  output reg                      o_serial_out,       // Pass-through data
  output reg                      o_ready,            // Normal operation allowed
  output reg  [`SSC_SETUP_LEN-1:0] o_setup            // Loaded setup bits
);
  localparam [1:0] ST_IDLE = `SSC_ST_IDLE;
  localparam [1:0] ST_LOAD = `SSC_ST_LOAD;
  localparam [1:0] ST_DONE = `SSC_ST_DONE;
  localparam [`SSC_LEN_W-1:0] LEN = `SSC_SETUP_LEN;

  wire sclk_rise;
  wire en_lvl;
  wire si_lvl;
  wire mode_lvl;
  reg  [1:0]             state_r;
  reg  [`SSC_LEN_W-1:0]  cnt_r;

  ssc_sync2 u_sclk (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_shift_clk),
    .i_rst_val (1'b0),
    .o_level   (),
    .o_rise    (sclk_rise)
  );
  ssc_sync2 u_en (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_chain_enable_in),
    .i_rst_val (1'b0),
    .o_level   (en_lvl),
    .o_rise    ()
  );
  ssc_sync2 u_si (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_serial_in),
    .i_rst_val (1'b0),
    .o_level   (si_lvl),
    .o_rise    ()
  );
  // Strap is a pin, so it is synchronised too
  ssc_sync2 u_mode (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_serial_mode),
    .i_rst_val (1'b0),
    .o_level   (mode_lvl),
    .o_rise    ()
  );

  // Mode strap read once its synchroniser has settled
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
      cnt_r   <= {`SSC_LEN_W{1'b0}};
      o_setup <= {`SSC_SETUP_LEN{1'b0}};
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (cnt_r == `SSC_STRAP_WAIT) begin
            cnt_r   <= {`SSC_LEN_W{1'b0}};
            state_r <= mode_lvl ? ST_LOAD : ST_DONE;
          end else begin
            cnt_r <= cnt_r + 16'd1;
          end
        end
        ST_LOAD: begin
          // sample data on shift clock rise
          if (sclk_rise && !en_lvl) begin
            o_setup <= {o_setup[`SSC_SETUP_LEN-2:0], si_lvl};
            if (cnt_r == LEN - 16'd1)
              state_r <= ST_DONE;
            cnt_r <= cnt_r + 16'd1;
          end
        end
        ST_DONE: begin
          state_r <= ST_DONE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Outputs registered
  always @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_chain_enable_out <= 1'b1;
      o_serial_out       <= 1'b0;
      o_ready            <= 1'b0;
    end else if (state_r == ST_DONE) begin
      o_chain_enable_out <= en_lvl;
      o_ready            <= o_ready | ~en_lvl;
      // pass data once enable out low
      o_serial_out       <= o_chain_enable_out ? 1'b0 : si_lvl;
    end else begin
      o_chain_enable_out <= 1'b1;
      o_serial_out       <= 1'b0;
      o_ready            <= 1'b0;
    end
  end
endmodule

// >>> sim/ssc_host.sv
// Host model driving the loader serial port
module ssc_host (
  input logic clk  // Bench clock
);
  timeunit 1ns; timeprecision 1ns;
  // one host owns first enable and shared clock
  logic sclk = 0, sen = 1, sdat = 0;
  // Data set, clock high four cycles later, low four after that
  task automatic send(logic [63:0] x, int n);
    @(posedge clk) sen <= 0;
    for (int k = 0; k < n; k++) begin
      @(posedge clk) sdat <= x[63-k];
      repeat (4) @(posedge clk);
      sclk <= 1;
      repeat (4) @(posedge clk);
      sclk <= 0;
    end
    @(posedge clk) sdat <= ~sdat;
  endtask
endmodule

// >>> sim/ssc_checker.sv
// Port assertions for the setup loader
`include "ssc_defines.vh"
module ssc_checker (
  input logic i_sys_clk, i_rst_n, i_serial_mode, i_shift_clk, i_serial_in,
  input logic i_chain_enable_in, o_chain_enable_out, o_serial_out, o_ready,
  input logic [`SSC_SETUP_LEN-1:0] o_setup);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  AST_RDY:
    assert property (!o_chain_enable_out |-> ##[0:2] o_ready) else $error("r");
  AST_LO:
    assert property ((o_ready && !i_chain_enable_in)[*6] |->
      !o_chain_enable_out) else $error("l");
  AST_HI:
    assert property ((o_ready && i_chain_enable_in)[*6] |->
      o_chain_enable_out) else $error("h");
  AST_DEF:
    assert property ((!i_serial_mode && !i_chain_enable_in)[*8] |->
      !o_chain_enable_out) else $error("d");
  AST_PASS:
    assert property ((!o_chain_enable_out && $stable(i_serial_in))[*5] |->
      o_serial_out == i_serial_in) else $error("p");
  AST_SHIFT:
    assert property ($changed(o_setup) |->
      o_setup[63:1] == $past(o_setup[62:0])) else $error("s");
  AST_HOLD:
    assert property (o_ready |=> $stable(o_setup)) else $error("f");
  AST_EARLY:
    assert property ($changed(o_setup) |-> o_chain_enable_out) else $error("e");
  cover property ($fell(o_chain_enable_out));
  cover property ($rose(o_ready) && i_serial_mode);
  cover property ($rose(o_chain_enable_out) && o_ready);
endmodule
bind ssc_loader ssc_checker i_ssc_checker (.*);

// >>> sim/tb.sv
// Self-checking bench for the setup loader
module tb;
  timeunit 1ns; timeprecision 1ns;
  logic clk = 0, rst_n = 0, mode = 1, eo, so, rdy;
  logic eo2;
  logic [63:0] q, v, q2;
  int err_total = 0, n_tests = 0;
  always #25 clk = ~clk;
  ssc_host i_host (.clk(clk));
  ssc_loader i_ssc_loader (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_serial_mode(mode), .i_shift_clk(i_host.sclk), .i_serial_in(i_host.sdat),
    .i_chain_enable_in(i_host.sen), .o_chain_enable_out(eo),
    .o_serial_out(so), .o_ready(rdy), .o_setup(q));
  // second device fed from first; its data out left open
  ssc_loader i_ssc_loader_dn (.i_sys_clk(clk), .i_rst_n(rst_n),
    .i_serial_mode(mode), .i_shift_clk(i_host.sclk), .i_serial_in(so),
    .i_chain_enable_in(eo), .o_chain_enable_out(eo2),
    .o_serial_out(), .o_ready(), .o_setup(q2));
  task automatic ck(logic [63:0] e, g, string s);
    n_tests++;
    if (g !== e) begin err_total++; $display("FAIL %s exp %h got %h", s, e, g); end
  endtask
  task automatic w8(); repeat (8) @(posedge clk); endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin #400us; err_total++; complete_run(); end
  initial begin
    void'($urandom(96)); v = {$urandom, $urandom};
    repeat (4) @(posedge clk); rst_n <= 1; w8();
    i_host.send(v, 63); w8();
    ck(v >> 1, q, "q");
    ck(1, eo, "eo");
    ck(0, rdy, "rdy");
    i_host.send(v << 63, 1); w8();
    ck(v, q, "q");
    ck(0, eo, "eo");
    ck(1, rdy, "rdy");
    i_host.send(~v, 4); w8();
    ck(v, q, "q");
    ck({60'h0, ~v[63:60]}, q2, "q2");
    ck(1, eo2, "eo2");
    // queue traffic only once the enable output is low
    repeat (12) begin
      i_host.sdat <= 1'($urandom); w8();
      ck(i_host.sdat, so, "so");
    end
    i_host.sen <= 1; w8();
    ck(1, eo, "eo");
    rst_n <= 0; mode <= 0; i_host.sen <= 0; w8(); rst_n <= 1; w8(); w8();
    ck(0, eo, "eo");
    ck(0, eo2, "eo2");
    complete_run();
  end
endmodule
